// ### verilog/sspi_pkg.sv
// constants, field layouts and types shared by the serial port register bank
// assumes a 32-bit apb register bus
package sspi_pkg;
  localparam logic [31:0] BASE_ADDR = 32'h4040_0000;
  localparam logic [7:0] OFF_CONTROL_WORD_ZERO = 8'h00;
  localparam logic [7:0] OFF_CONTROL_WORD_ONE = 8'h04;
  localparam logic [7:0] OFF_QUEUE_DATA = 8'h08;
  localparam logic [7:0] OFF_PORT_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CLOCK_PRESCALER = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_IRQ_RAW_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASKED_STATUS = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] OFF_DMA_CONTROL = 8'h24;
  localparam logic [7:0] OFF_RX_FRAME_COUNT = 8'h28;
  localparam logic [7:0] OFF_FILLER_WORD = 8'h2c;
  localparam logic [7:0] OFF_TX_FRAME_COUNT = 8'h30;
  localparam logic [7:0] OFF_TEST_CONTROL = 8'h80;
  localparam logic [7:0] OFF_TEST_DATA = 8'h8c;
  localparam logic [31:0] RST_CONTROL_WORD_ZERO = 32'h1c00_0000;
  localparam logic [31:0] RST_PORT_STATUS = 32'h0000_0003;
  // control word one: port enable bit
  localparam int CW1_ENABLE_BIT = 1;
  // port status bits
  localparam int ST_TX_EMPTY_BIT = 0;
  localparam int ST_TX_NOT_FULL_BIT = 1;
  localparam int ST_RX_NOT_EMPTY_BIT = 2;
  localparam int ST_RX_FULL_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  // raw event bits
  localparam int EV_RX_OVERRUN_BIT = 0;
  localparam int EV_RX_READY_BIT = 2;
  localparam int EV_TX_EMPTY_BIT = 3;
  localparam logic [1:0] FMT_FOUR_WIRE = 2'h0;
  localparam logic [1:0] FMT_THREE_WIRE = 2'h2;
  localparam logic [4:0] MIN_SIZE_FIELD = 5'h03;

  typedef enum logic [1:0] {
    MODE_FULL_DUPLEX = 2'b00,
    MODE_TRANSMIT = 2'b01,
    MODE_RECEIVE = 2'b10,
    MODE_COMBINED = 2'b11
  } xfer_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_STORE = 2'b11
  } engine_state_e;

  typedef struct packed {
    logic [4:0] reserved_top;
    logic slave_one_select;
    logic reserved_25;
    xfer_mode_e master_transfer_mode;
    logic [1:0] frame_format_field;
    logic [4:0] command_size_field;
    logic [7:0] serial_clock_rate_field;
    logic capture_phase;
    logic idle_clock_level;
    logic reserved_5;
    logic [4:0] word_size_field;
  } control_zero_s;

  typedef struct packed {
    logic sclk;
    logic data_out;
    logic data_oe;
    logic slave_one_select_n;
  } serial_pins_s;
endpackage

// ### verilog/sspi_port.sv
// register bank and master shift engine of a synchronous serial port
// assumes an apb master on pclk and slave devices on the serial pins
//
// Summary of operation
// - word size field bits 4:0, length plus one
// - bit 6 sets idle serial clock level
// - bit 7 selects capture clock phase
// - bit rate is clock over divisor times rate plus one
// - command size bits 20:16, three-wire only
// - format 0 four-wire, format 2 three-wire
// - bits 24:23 pick master transfer mode
// - bit 26 drives slave-one select, resets deselected
// - control word zero at 0x00, reset 0x1C000000
// - status at 0x0C read-only, reset 0x3
// - clear register at 0x20 clears latched events
// - mask, raw and masked status registers
// - receive frame count register at 0x28
// - transmit frame count register at 0x30
// - dma control at 0x24, data at 0x08
// - test control 0x80, test data 0x8C
// - offsets decoded from base 0x40400000
// - receive count decremented only with empty queue
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module sspi_port
  import sspi_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk, // apb clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic data_in, // serial input from slave
  output serial_pins_s pins // serial clock, data out, enable, select
);

  control_zero_s cw0;
  logic [31:0] cw1;
  logic [7:0] prescale_divisor;
  logic [31:0] irq_mask;
  logic [31:0] dma_control;
  logic [CNT_W-1:0] rx_frame_count;
  logic [CNT_W-1:0] tx_frame_count;
  logic [31:0] filler_word;
  logic [31:0] test_control;
  logic [31:0] test_data;
  logic [31:0] tx_word;
  logic tx_full;
  logic [31:0] rx_word;
  logic rx_full;
  logic rx_overrun;

  engine_state_e state;
  logic [15:0] half_cnt;
  logic [6:0] edge_cnt;
  logic [6:0] smp_cnt;
  logic [6:0] total_q;
  logic [5:0] cmd_q;
  logic [31:0] mask_q;
  logic [31:0] tx_sh;
  logic [31:0] rx_sh;
  logic cpha_q;
  logic store_q;
  logic three_q;
  logic [15:0] half_q;
  logic sclk_tog;
  logic data_q;

  // bus decode
  wire in_range = paddr[31:8] == BASE_ADDR[31:8];
  wire [7:0] off = paddr[7:0];
  wire hit_cw0 = in_range && off == OFF_CONTROL_WORD_ZERO;
  wire hit_cw1 = in_range && off == OFF_CONTROL_WORD_ONE;
  wire hit_data = in_range && off == OFF_QUEUE_DATA;
  wire hit_stat = in_range && off == OFF_PORT_STATUS;
  wire hit_clock_prescaler = in_range && off == OFF_CLOCK_PRESCALER;
  wire hit_mask = in_range && off == OFF_IRQ_MASK;
  wire hit_raw = in_range && off == OFF_IRQ_RAW_STATUS;
  wire hit_mis = in_range && off == OFF_IRQ_MASKED_STATUS;
  wire hit_icr = in_range && off == OFF_IRQ_CLEAR;
  wire hit_dma = in_range && off == OFF_DMA_CONTROL;
  wire hit_rxf = in_range && off == OFF_RX_FRAME_COUNT;
  wire hit_fill = in_range && off == OFF_FILLER_WORD;
  wire hit_txf = in_range && off == OFF_TX_FRAME_COUNT;
  wire hit_tctl = in_range && off == OFF_TEST_CONTROL;
  wire hit_tdat = in_range && off == OFF_TEST_DATA;
  wire hit_any = hit_cw0 | hit_cw1 | hit_data | hit_stat | hit_clock_prescaler | hit_mask | hit_raw
    | hit_mis | hit_icr | hit_dma | hit_rxf | hit_fill | hit_txf | hit_tctl | hit_tdat;
  // read-only registers take no writes; a write to them is refused with an error
  wire ro_hit = hit_stat | hit_raw | hit_mis;
  wire wo_hit = hit_icr;
  wire access = psel && penable;
  wire unmapped = !hit_any;
  wire ro_write = pwrite && ro_hit;
  wire wo_read = !pwrite && wo_hit;
  wire bad = unmapped || ro_write || wo_read;
  wire wr = access && pwrite && !bad;
  wire rd = access && !pwrite && !bad;

  // status and events
  wire enabled = cw1[CW1_ENABLE_BIT];
  wire busy = state != ST_IDLE;
  logic [31:0] status_word;
  logic [31:0] raw_events;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_TX_EMPTY_BIT] = !tx_full;
    status_word[ST_TX_NOT_FULL_BIT] = !tx_full;
    status_word[ST_RX_NOT_EMPTY_BIT] = rx_full;
    status_word[ST_RX_FULL_BIT] = rx_full;
    status_word[ST_BUSY_BIT] = busy;
    raw_events = 32'h0000_0000;
    raw_events[EV_RX_OVERRUN_BIT] = rx_overrun;
    raw_events[EV_RX_READY_BIT] = rx_full;
    // gated by enable so the raw register shows zero out of reset
    raw_events[EV_TX_EMPTY_BIT] = enabled && !tx_full;
  end

  // read selection, unmapped or refused reads return zero
  wire [31:0] rd_mux =
    hit_cw0 ? cw0 :
    hit_cw1 ? cw1 :
    hit_data ? rx_word :
    hit_stat ? status_word :
    hit_clock_prescaler ? {24'h00_0000, prescale_divisor} :
    hit_mask ? irq_mask :
    hit_raw ? raw_events :
    hit_mis ? (raw_events & irq_mask) :
    hit_dma ? dma_control :
    hit_rxf ? 32'(rx_frame_count) :
    hit_fill ? filler_word :
    hit_txf ? 32'(tx_frame_count) :
    hit_tctl ? test_control :
    hit_tdat ? test_data :
    32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access && bad;
  assign prdata = (!pwrite && !bad) ? rd_mux : 32'h0000_0000;

  // word-start decision
  wire three_wire = cw0.frame_format_field == FMT_THREE_WIRE;
  // reserved sizes below four bits run as four bits, so software always gets a defined frame
  wire [4:0] word_size_eff = (cw0.word_size_field < MIN_SIZE_FIELD) ? MIN_SIZE_FIELD : cw0.word_size_field;
  wire [4:0] cmd_size_eff = (cw0.command_size_field < MIN_SIZE_FIELD) ? MIN_SIZE_FIELD : cw0.command_size_field;
  wire [5:0] data_len = {1'b0, word_size_eff} + 6'h01;
  wire [5:0] cmd_len = {1'b0, cmd_size_eff} + 6'h01;
  wire rxf_nz = rx_frame_count != '0;
  wire txf_nz = tx_frame_count != '0;
  logic go;
  logic use_filler;
  logic dec_rxf;
  logic dec_txf;
  always_comb begin
    go = 1'b0;
    use_filler = 1'b0;
    dec_rxf = 1'b0;
    dec_txf = 1'b0;
    if (three_wire) begin
      go = tx_full;
    end else begin
      unique case (cw0.master_transfer_mode)
        MODE_FULL_DUPLEX, MODE_TRANSMIT: go = tx_full;
        MODE_RECEIVE: begin
          go = tx_full || rxf_nz;
          use_filler = !tx_full;
          dec_rxf = !tx_full && rxf_nz;
        end
        MODE_COMBINED: begin
          // queue words first, filler words only once the transmit count is spent
          go = txf_nz ? tx_full : rxf_nz;
          use_filler = !txf_nz;
          dec_txf = txf_nz && tx_full;
          dec_rxf = !txf_nz && rxf_nz && !tx_full;
        end
      endcase
    end
  end
  wire start = state == ST_IDLE && enabled && go;
  wire [31:0] src = use_filler ? filler_word : tx_word;

  // bit timing: half bit = divisor/2 * (rate+1) clocks
  wire [6:0] div_half = (prescale_divisor[7:1] == 7'h00) ? 7'h01 : prescale_divisor[7:1];
  wire [15:0] half_per = 16'(div_half * ({1'b0, cw0.serial_clock_rate_field} + 9'h001));
  wire [6:0] start_total = three_wire ? 7'(cmd_len) + 7'(data_len) : 7'(data_len);
  wire [5:0] start_shift_len = three_wire ? cmd_len : data_len;
  wire [31:0] aligned = src << (6'd32 - start_shift_len);
  wire [31:0] len_mask = 32'hffff_ffff >> (6'd32 - data_len);

  // data_in is taken on the pclk edge that launches a sample edge, so the slave's bit
  // must already stand from its previous shift edge
  wire tick = state == ST_SHIFT && half_cnt == 16'h0000;
  wire lead = !edge_cnt[0];
  wire sample_edge = lead != cpha_q;
  wire last_edge = edge_cnt == 7'((total_q << 1) - 7'h01);
  wire rx_done = state == ST_STORE;

  // engine state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (start) state <= ST_SHIFT;
        ST_SHIFT: if (tick && last_edge) state <= ST_STORE;
        ST_STORE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // per-word settings are frozen at word start, so mode changes take effect next word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_q <= 7'h00;
      cmd_q <= 6'h00;
      mask_q <= 32'h0000_0000;
      cpha_q <= 1'b0;
      store_q <= 1'b0;
      three_q <= 1'b0;
      half_q <= 16'h0000;
    end else if (start) begin
      total_q <= start_total;
      cmd_q <= cmd_len;
      mask_q <= len_mask;
      cpha_q <= cw0.capture_phase;
      store_q <= three_wire || cw0.master_transfer_mode != MODE_TRANSMIT;
      three_q <= three_wire;
      half_q <= half_per;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 16'h0000;
      edge_cnt <= 7'h00;
      smp_cnt <= 7'h00;
      sclk_tog <= 1'b0;
    end else if (start) begin
      half_cnt <= half_per - 16'h0001;
      edge_cnt <= 7'h00;
      smp_cnt <= 7'h00;
      sclk_tog <= 1'b0;
    end else if (state == ST_SHIFT) begin
      half_cnt <= tick ? half_q - 16'h0001 : half_cnt - 16'h0001;
      if (tick) begin
        edge_cnt <= edge_cnt + 7'h01;
        sclk_tog <= !sclk_tog;
        if (sample_edge) smp_cnt <= smp_cnt + 7'h01;
      end
    end
  end

  // shift registers, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh <= 32'h0000_0000;
      rx_sh <= 32'h0000_0000;
      data_q <= 1'b0;
    end else if (start) begin
      // phase 0 puts the first bit out before the first edge
      tx_sh <= cw0.capture_phase ? aligned : {aligned[30:0], 1'b0};
      data_q <= cw0.capture_phase ? 1'b0 : aligned[31];
      rx_sh <= 32'h0000_0000;
    end else if (tick) begin
      if (sample_edge) begin
        rx_sh <= {rx_sh[30:0], data_in};
      end else begin
        data_q <= tx_sh[31];
        tx_sh <= {tx_sh[30:0], 1'b0};
      end
    end
  end

  // transmit holding word and frame counters
  wire pop_tx = start && !use_filler;
  wire push_tx = wr && hit_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_word <= 32'h0000_0000;
      tx_full <= 1'b0;
    end else begin
      if (push_tx) tx_word <= pwdata;
      // a write in the same cycle as the pop refills the word
      tx_full <= push_tx || (tx_full && !pop_tx);
    end
  end

  wire rxf_wr = wr && hit_rxf;
  wire txf_wr = wr && hit_txf;
  // software writes override a decrement in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame_count <= '0;
    end else if (rxf_wr) begin
      rx_frame_count <= pwdata[CNT_W-1:0];
    end else if (start && dec_rxf) begin
      rx_frame_count <= rx_frame_count - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_frame_count <= '0;
    end else if (txf_wr) begin
      tx_frame_count <= pwdata[CNT_W-1:0];
    end else if (start && dec_txf) begin
      tx_frame_count <= tx_frame_count - CNT_W'(1);
    end
  end

  // receive holding word; overrun keeps the old word
  wire pop_rx = rd && hit_data;
  wire push_rx = rx_done && store_q;
  wire overrun_ev = push_rx && rx_full && !pop_rx;
  wire clr_overrun = wr && hit_icr && pwdata[EV_RX_OVERRUN_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word <= 32'h0000_0000;
      rx_full <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      if (push_rx && (!rx_full || pop_rx)) rx_word <= rx_sh & mask_q;
      rx_full <= push_rx || (rx_full && !pop_rx);
      // set wins over a clear in the same cycle
      rx_overrun <= overrun_ev || (rx_overrun && !clr_overrun);
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw0 <= control_zero_s'(RST_CONTROL_WORD_ZERO);
      cw1 <= 32'h0000_0000;
      prescale_divisor <= 8'h00;
      irq_mask <= 32'h0000_0000;
      dma_control <= 32'h0000_0000;
      filler_word <= 32'h0000_0000;
      test_control <= 32'h0000_0000;
      test_data <= 32'h0000_0000;
    end else if (wr) begin
      if (hit_cw0) cw0 <= control_zero_s'(pwdata);
      if (hit_cw1) cw1 <= pwdata;
      if (hit_clock_prescaler) prescale_divisor <= pwdata[7:0];
      if (hit_mask) irq_mask <= pwdata;
      if (hit_dma) dma_control <= pwdata;
      if (hit_fill) filler_word <= pwdata;
      if (hit_tctl) test_control <= pwdata;
      if (hit_tdat) test_data <= pwdata;
    end
  end

  // pins; three-wire drives the shared line only while the command goes out
  wire three_drive = three_q && busy && smp_cnt < 7'(cmd_q);
  // a word runs on the format frozen at its start; between words the enable follows the register
  wire word_oe = three_q ? three_drive : 1'b1;
  wire idle_oe = !three_wire;
  assign pins.sclk = cw0.idle_clock_level ^ sclk_tog;
  assign pins.data_out = data_q;
  assign pins.data_oe = busy ? word_oe : idle_oe;
  assign pins.slave_one_select_n = cw0.slave_one_select;

endmodule

// ### verification/sspi_port_properties.sv
// concurrent checks on the register bus and serial pins of sspi_port
// assumes binding into sspi_port; one clock domain
`timescale 1ns/1ns
module sspi_port_properties
  import sspi_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [31:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic data_in, // serial in
  input wire serial_pins_s pins // serial pins
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [31:0] cw0;
  logic [7:0] div;
  logic en;
  logic prev_sclk;
  logic cfg_d;
  logic [15:0] gap;
  int half;
  wire logic ours = paddr[31:8] == BASE_ADDR[31:8];
  wire logic wr_hit = psel && penable && pwrite && ours;
  wire logic cw0_wr = wr_hit && paddr[7:0] == OFF_CONTROL_WORD_ZERO;
  wire logic cw1_wr = wr_hit && paddr[7:0] == OFF_CONTROL_WORD_ONE;
  wire logic div_wr = wr_hit && paddr[7:0] == OFF_CLOCK_PRESCALER;
  wire logic sclk_moved = pins.sclk != prev_sclk;
  // a divisor below two runs as two, so a half period never drops under one clock
  assign half = (div < 8'h02 ? 1 : int'(div[7:1])) * (int'(cw0[15:8]) + 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw0 <= RST_CONTROL_WORD_ZERO;
      div <= 8'h00;
      en <= 1'b0;
      prev_sclk <= 1'b0;
      cfg_d <= 1'b0;
      gap <= 16'h0000;
    end else begin
      cw0 <= cw0_wr ? pwdata : cw0;
      div <= div_wr ? pwdata[7:0] : div;
      en <= cw1_wr ? pwdata[CW1_ENABLE_BIT] : en;
      prev_sclk <= pins.sclk;
      cfg_d <= cw0_wr || cw1_wr || div_wr;
      gap <= sclk_moved ? 16'h0001 : gap + {15'h0000, gap != 16'hffff};
    end
  end
  sequence s_hit(logic [7:0] off, logic wr);
    psel && penable && ours && pwrite == wr && paddr[7:0] == off;
  endsequence
  property p_select;
    pins.slave_one_select_n == cw0[26];
  endproperty
  a_select: assert property (p_select) else $error("select pin differs from control bit");
  property p_cw0_read;
    s_hit(OFF_CONTROL_WORD_ZERO, 1'b0) |-> prdata == cw0 && !pslverr;
  endproperty
  a_cw0_read: assert property (p_cw0_read) else $error("control word zero read wrong");
  property p_status_ro;
    s_hit(OFF_PORT_STATUS, 1'b1) |-> pslverr;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write accepted");
  property p_clear_wo;
    s_hit(OFF_IRQ_CLEAR, 1'b0) |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_clear_wo: assert property (p_clear_wo) else $error("clear register readable");
  property p_base;
    psel && penable && !ours |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_base: assert property (p_base) else $error("foreign address answered");
  property p_idle;
    !en |-> pins.sclk == cw0[6];
  endproperty
  a_idle: assert property (p_idle) else $error("serial clock not at idle level");
  property p_oe;
    cw0[22:21] != FMT_THREE_WIRE |-> pins.data_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("data output released in four-wire format");
  property p_half;
    sclk_moved && !cfg_d |-> gap == half || (pins.sclk != cw0[6] && gap > half);
  endproperty
  a_half: assert property (p_half) else $error("serial clock half period wrong");
endmodule

bind sspi_port sspi_port_properties #(.CNT_W(CNT_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in), .pins(pins)
);

// ### verification/serial_slave_model.sv
// behavioural serial slave returning one byte msb first
// captures on leading edges in phase zero, on trailing in phase one; always shifts on trailing
`timescale 1ns/1ns
module serial_slave_model (
  input wire logic sclk, // serial clock from the port
  input wire logic mosi, // data from the port
  input wire logic sel_n, // select, active low
  input wire logic idle_level, // clock level between words
  input wire logic phase, // high: capture on trailing edges
  input wire logic load, // rising edge loads the reply
  input wire logic [7:0] reply, // word to return
  output logic miso, // data to the port
  output logic [7:0] got // last bits captured
);
  logic [7:0] shreg;
  logic last;
  initial begin
    shreg = 8'h00;
    got = 8'h00;
    last = 1'b0;
  end
  // the line has no pull, so a released line shows the inverse of the last bit
  assign miso = sel_n ? ~last : shreg[7];
  always @(posedge load) shreg = reply;
  always @(sclk) begin
    if (!sel_n && ((sclk != idle_level) != phase)) begin
      got = {got[6:0], mosi};
      last = shreg[7];
    end
    if (!sel_n && sclk == idle_level) shreg = {shreg[6:0], ~shreg[0]};
  end
endmodule

// ### verification/tb_spi_register_map_control0.sv
// self-checking bench for the serial port register bank and shift engine
// assumes the slave model on the serial pins and a 100 MHz pclk
`timescale 1ns/1ns
module tb_spi_register_map_control0;
  import sspi_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, data_in, load, idle_lvl, phase_lvl, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] got;
  serial_pins_s pins;
  int miscompares, checks;
  sspi_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in),
    .pins(pins));
  serial_slave_model u_slave (.sclk(pins.sclk), .mosi(pins.data_out), .sel_n(pins.slave_one_select_n),
    .idle_level(idle_lvl), .phase(phase_lvl), .load(load), .reply(8'h96), .miso(data_in), .got(got));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic expect32(input logic [31:0] act, input logic [31:0] exp, input string what);
    checks++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, act, exp);
    end
  endtask
  // entered just after a rising edge; returns one idle cycle after the handshake
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    logic rdy;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (rdy !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED t=%0t no ready", $time);
      close_out();
    end
  endtask
  task automatic wrr(input logic [7:0] off, input logic [31:0] d);
    apb(1'b1, {BASE_ADDR[31:8], off}, d);
  endtask
  task automatic rdx(input logic [7:0] off, input logic [31:0] exp, input string what);
    apb(1'b0, {BASE_ADDR[31:8], off}, 32'h0000_0000);
    expect32(rd, exp, what);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, {BASE_ADDR[31:8], OFF_PORT_STATUS}, 32'h0000_0000);
      n++;
    end while ((rd[ST_BUSY_BIT] !== 1'b0 || rd[ST_TX_EMPTY_BIT] !== 1'b1) && n < 200);
    if (n >= 200) begin
      miscompares++;
      $display("CHECK FAILED t=%0t serial word never finished", $time);
      close_out();
    end
  endtask
  task automatic t_reset;
    logic [7:0] offs [12] = '{OFF_CONTROL_WORD_ONE, OFF_QUEUE_DATA, OFF_CLOCK_PRESCALER, OFF_IRQ_MASK,
      OFF_IRQ_RAW_STATUS, OFF_IRQ_MASKED_STATUS, OFF_DMA_CONTROL, OFF_RX_FRAME_COUNT, OFF_FILLER_WORD,
      OFF_TX_FRAME_COUNT, OFF_TEST_CONTROL, OFF_TEST_DATA};
    rdx(OFF_CONTROL_WORD_ZERO, RST_CONTROL_WORD_ZERO, "control zero reset");
    rdx(OFF_PORT_STATUS, RST_PORT_STATUS, "status reset");
    expect32({31'h0, pins.slave_one_select_n}, 32'h0000_0001, "select after reset");
    foreach (offs[i]) rdx(offs[i], 32'h0000_0000, "register reset");
  endtask
  task automatic t_access;
    logic [7:0] rw [7] = '{OFF_IRQ_MASK, OFF_DMA_CONTROL, OFF_RX_FRAME_COUNT, OFF_FILLER_WORD,
      OFF_TX_FRAME_COUNT, OFF_TEST_CONTROL, OFF_TEST_DATA};
    foreach (rw[i]) begin
      wrr(rw[i], 32'h0000_0001);
      rdx(rw[i], 32'h0000_0001, "read back");
      wrr(rw[i], 32'h0000_0000);
    end
    wrr(OFF_PORT_STATUS, 32'hffff_ffff);
    expect32({31'h0, err}, 32'h0000_0001, "status write refused");
    rdx(OFF_PORT_STATUS, RST_PORT_STATUS, "status unchanged");
    rdx(OFF_IRQ_CLEAR, 32'h0000_0000, "clear reads zero");
    expect32({31'h0, err}, 32'h0000_0001, "clear read refused");
    apb(1'b1, 32'h5040_0000, 32'h0000_0001);
    expect32({31'h0, err}, 32'h0000_0001, "foreign base refused");
    wrr(OFF_CONTROL_WORD_ZERO, RST_CONTROL_WORD_ZERO | 32'h0040_0000);
    expect32({31'h0, pins.data_oe}, 32'h0000_0000, "three-wire idle releases data");
    wrr(OFF_CONTROL_WORD_ZERO, RST_CONTROL_WORD_ZERO);
  endtask
  task automatic t_case(input logic [4:0] size, input logic idle, input logic [1:0] fmt,
                        input xfer_mode_e mode, input logic [7:0] tx, input logic [7:0] rxc, input logic [7:0] txc);
    control_zero_s cw;
    logic [7:0] mask;
    cw = RST_CONTROL_WORD_ZERO;
    cw.word_size_field = size;
    cw.idle_clock_level = idle;
    cw.capture_phase = phase_lvl;
    cw.serial_clock_rate_field = 8'h01;
    cw.frame_format_field = fmt;
    cw.master_transfer_mode = mode;
    mask = 8'hff >> (5'd7 - size);
    idle_lvl <= idle;
    load <= 1'b0;
    wrr(OFF_CONTROL_WORD_ZERO, cw);
    cw.slave_one_select = 1'b0;
    load <= 1'b1;
    wrr(OFF_CONTROL_WORD_ZERO, cw);
    wrr(OFF_FILLER_WORD, {24'h00_0000, tx});
    wrr(OFF_TX_FRAME_COUNT, {24'h00_0000, txc});
    wrr(OFF_CONTROL_WORD_ONE, 32'h0000_0001 << CW1_ENABLE_BIT);
    if (rxc != 8'h00) wrr(OFF_RX_FRAME_COUNT, {24'h00_0000, rxc});
    else wrr(OFF_QUEUE_DATA, {24'h00_0000, tx});
    wait_idle();
    expect32({24'h0, got & mask}, {24'h0, tx & mask}, "word seen by slave");
    if (mode == MODE_TRANSMIT) begin
      apb(1'b0, {BASE_ADDR[31:8], OFF_PORT_STATUS}, 32'h0000_0000);
      expect32({31'h0, rd[ST_RX_NOT_EMPTY_BIT]}, 32'h0000_0000, "transmit mode keeps no word");
    end else rdx(OFF_QUEUE_DATA, {24'h0, 8'h96 >> (5'd7 - size)}, "received word");
    rdx(OFF_RX_FRAME_COUNT, 32'h0000_0000, "receive count spent");
    rdx(OFF_TX_FRAME_COUNT, 32'h0000_0000, "transmit count spent");
    wrr(OFF_CONTROL_WORD_ONE, 32'h0000_0000);
    cw.slave_one_select = 1'b1;
    wrr(OFF_CONTROL_WORD_ZERO, cw);
  endtask
  task automatic t_overrun;
    load <= 1'b0;
    wrr(OFF_CONTROL_WORD_ZERO, 32'h1800_0107);
    load <= 1'b1;
    wrr(OFF_CONTROL_WORD_ONE, 32'h0000_0001 << CW1_ENABLE_BIT);
    repeat (2) begin
      wrr(OFF_QUEUE_DATA, 32'h0000_0011);
      wait_idle();
    end
    apb(1'b0, {BASE_ADDR[31:8], OFF_IRQ_RAW_STATUS}, 32'h0000_0000);
    expect32({31'h0, rd[EV_RX_OVERRUN_BIT]}, 32'h0000_0001, "overrun raised");
    wrr(OFF_IRQ_MASK, 32'h0000_0001);
    rdx(OFF_IRQ_MASKED_STATUS, 32'h0000_0001, "masked overrun");
    wrr(OFF_IRQ_CLEAR, 32'h0000_0001);
    rdx(OFF_IRQ_MASKED_STATUS, 32'h0000_0000, "overrun cleared");
    rdx(OFF_QUEUE_DATA, 32'h0000_0096, "first word kept");
    wrr(OFF_IRQ_MASK, 32'h0000_0000);
    wrr(OFF_CONTROL_WORD_ONE, 32'h0000_0000);
    wrr(OFF_CONTROL_WORD_ZERO, 32'h1c00_0107);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    load = 1'b0;
    idle_lvl = 1'b0;
    phase_lvl = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_access();
    wrr(OFF_CLOCK_PRESCALER, 32'h0000_0004);
    t_case(5'h03, 1'b0, FMT_FOUR_WIRE, MODE_FULL_DUPLEX, 8'h0a, 8'h00, 8'h00);
    t_case(5'h07, 1'b1, 2'h1, MODE_FULL_DUPLEX, 8'hc3, 8'h00, 8'h00);
    t_case(5'h07, 1'b0, 2'h3, MODE_TRANSMIT, 8'h3c, 8'h00, 8'h00);
    t_case(5'h07, 1'b1, FMT_FOUR_WIRE, MODE_RECEIVE, 8'ha5, 8'h01, 8'h00);
    t_case(5'h07, 1'b0, FMT_FOUR_WIRE, MODE_COMBINED, 8'h71, 8'h00, 8'h01);
    t_overrun();
    phase_lvl <= 1'b1;
    @(posedge pclk);
    t_case(5'h07, 1'b1, FMT_FOUR_WIRE, MODE_FULL_DUPLEX, 8'h5a, 8'h00, 8'h00);
    close_out();
  end
endmodule
